// >>> core/event_cmp_pkg.sv
package event_cmp_pkg;

  // ==========================================================================
  // widths
  localparam int VAL_W = 16;
  localparam int EXT_W = 18;
  localparam int CODE_W = 6;
  localparam int INT_W = 3;

  // ==========================================================================
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MAIN = 8'h04;
  localparam logic [7:0] OFS_SUB = 8'h08;
  localparam logic [7:0] OFS_BAND = 8'h0c;
  localparam logic [7:0] OFS_STATE = 8'h10;
  localparam logic [7:0] OFS_INT_STAT = 8'h14;
  localparam logic [7:0] OFS_INT_MASK = 8'h18;

  // ==========================================================================
  // field positions and reset values
  localparam int CTRL_CODE_LSB = 0;
  localparam int CTRL_REV_BIT = 8;
  localparam int INT_RISE_BIT = 0;
  localparam int INT_FALL_BIT = 1;
  localparam int INT_MEAS_BIT = 2;
  localparam int HTRANS_ACT_BIT = 1;
  localparam logic [CODE_W-1:0] CODE_RST = 6'h00;
  localparam logic [VAL_W-1:0] MAIN_RST = 16'h0000;
  localparam logic [VAL_W-1:0] SUB_RST = 16'h0000;
  localparam logic [VAL_W-1:0] BAND_RST = 16'h0000;
  localparam logic [INT_W-1:0] MASK_RST = 3'h0;

  // ==========================================================================
  // operation type codes
  localparam logic [CODE_W-1:0] TYP_NONE = 6'h00;
  localparam logic [CODE_W-1:0] TYP_PROC_HI = 6'h01;
  localparam logic [CODE_W-1:0] TYP_PROC_LO = 6'h02;
  localparam logic [CODE_W-1:0] TYP_PROC_BAND = 6'h03;
  localparam logic [CODE_W-1:0] TYP_DEV_HI = 6'h04;
  localparam logic [CODE_W-1:0] TYP_DEV_LO = 6'h05;
  localparam logic [CODE_W-1:0] TYP_DEV_BAND = 6'h06;
  localparam logic [CODE_W-1:0] TYP_FDEV_HI = 6'h07;
  localparam logic [CODE_W-1:0] TYP_FDEV_LO = 6'h08;
  localparam logic [CODE_W-1:0] TYP_FDEV_BAND = 6'h09;
  localparam logic [CODE_W-1:0] TYP_SETP_HI = 6'h0a;
  localparam logic [CODE_W-1:0] TYP_SETP_LO = 6'h0b;
  localparam logic [CODE_W-1:0] TYP_SETP_BAND = 6'h0c;
  localparam logic [CODE_W-1:0] TYP_MANIP_HI = 6'h0d;
  localparam logic [CODE_W-1:0] TYP_MANIP_LO = 6'h0e;
  localparam logic [CODE_W-1:0] TYP_MANIP_BAND = 6'h0f;
  localparam logic [CODE_W-1:0] TYP_HEAT1_BURN = 6'h10;
  localparam logic [CODE_W-1:0] TYP_HEAT1_SHORT = 6'h11;
  localparam logic [CODE_W-1:0] TYP_HEAT2_BURN = 6'h12;
  localparam logic [CODE_W-1:0] TYP_HEAT2_SHORT = 6'h13;
  localparam logic [CODE_W-1:0] TYP_ALARM = 6'h17;
  localparam logic [CODE_W-1:0] TYP_READY = 6'h18;
  localparam logic [CODE_W-1:0] TYP_MANUAL = 6'h19;
  localparam logic [CODE_W-1:0] TYP_TUNING = 6'h1b;
  localparam logic [CODE_W-1:0] TYP_RAMP = 6'h1c;
  localparam logic [CODE_W-1:0] TYP_DIRECT = 6'h1d;
  localparam logic [CODE_W-1:0] TYP_TIMER = 6'h20;

  // sign extension of a 16-bit value into the comparison width
  function automatic logic [EXT_W-1:0] sext(input logic [VAL_W-1:0] v);
    return {{(EXT_W-VAL_W){v[VAL_W-1]}}, v};
  endfunction : sext

endpackage : event_cmp_pkg

// >>> core/hys_compare.sv
`timescale 1ns/1ps

module hys_compare (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // evaluation control
  input wire logic update,
  input wire logic clear,
  input wire logic use_hi,
  input wire logic use_lo,
  input wire logic edge_on_value,
  // operands, signed in comparison width, band unsigned
  input wire logic signed [event_cmp_pkg::EXT_W-1:0] value,
  input wire logic signed [event_cmp_pkg::EXT_W-1:0] lo_th,
  input wire logic signed [event_cmp_pkg::EXT_W-1:0] hi_th,
  input wire logic signed [event_cmp_pkg::EXT_W-1:0] band,
  // result
  output logic state_r
);

  // ==========================================================================
  // switching edges: at the value or only once exceeded
  wire logic signed [event_cmp_pkg::EXT_W-1:0] hi_rel = hi_th - band;
  wire logic signed [event_cmp_pkg::EXT_W-1:0] lo_rel = lo_th + band;
  wire logic hi_on = edge_on_value ? (value >= hi_th) : (value > hi_th);
  wire logic lo_on = edge_on_value ? (value <= lo_th) : (value < lo_th);
  wire logic hi_off = edge_on_value ? (value <= hi_rel) : (value < hi_rel);
  wire logic lo_off = edge_on_value ? (value >= lo_rel) : (value > lo_rel);
  wire logic set_on = (use_hi & hi_on) | (use_lo & lo_on);
  wire logic set_off = (~use_hi | hi_off) & (~use_lo | lo_off);
  logic state_nxt;

  // inside the band the previous state is kept
  assign state_nxt = clear ? 1'b0 :
                     (update & set_on) ? 1'b1 :
                     (update & set_off) ? 1'b0 : state_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================================
  // checks
  a_high_turn_on: assert property (@(posedge hclk) disable iff (!hresetn)
    update && !clear && use_hi && !use_lo && value > hi_th |=> state_r)
    else $error("high limit did not switch on");
  a_band_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    !clear && !(update && (set_on || set_off)) |=> state_r == $past(state_r))
    else $error("state changed inside the band");

endmodule : hys_compare

// >>> core/event_output_comparator.sv
`timescale 1ns/1ps

module event_output_comparator (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // measured values from the controller
  input wire logic meas_update,
  input wire logic [15:0] process_value,
  input wire logic [15:0] target_setpoint,
  input wire logic [15:0] final_setpoint,
  input wire logic [15:0] manipulated_value,
  input wire logic [15:0] current_sensor_one,
  input wire logic [15:0] current_sensor_two,
  input wire logic control_out_on,
  // controller status
  input wire logic alarm_any,
  input wire logic ready_state,
  input wire logic manual_mode,
  input wire logic auto_tuning,
  input wire logic setpoint_ramping,
  input wire logic direct_action,
  input wire logic timer_state,
  // results
  output logic event_out,
  output logic irq
);

  localparam int VW = event_cmp_pkg::VAL_W;
  localparam int EW = event_cmp_pkg::EXT_W;
  localparam int CW = event_cmp_pkg::CODE_W;
  localparam int IW = event_cmp_pkg::INT_W;

  // ==========================================================================
  // register decode, shared by reads and writes
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction : hit

  // which side of the comparison a code uses, {hi, lo}
  function automatic logic [1:0] sides_of(input logic [CW-1:0] c);
    case (c)
      event_cmp_pkg::TYP_PROC_HI, event_cmp_pkg::TYP_DEV_HI, event_cmp_pkg::TYP_FDEV_HI,
      event_cmp_pkg::TYP_SETP_HI, event_cmp_pkg::TYP_MANIP_HI,
      event_cmp_pkg::TYP_HEAT1_SHORT, event_cmp_pkg::TYP_HEAT2_SHORT: return 2'b10;
      event_cmp_pkg::TYP_PROC_LO, event_cmp_pkg::TYP_DEV_LO, event_cmp_pkg::TYP_FDEV_LO,
      event_cmp_pkg::TYP_SETP_LO, event_cmp_pkg::TYP_MANIP_LO: return 2'b01;
      event_cmp_pkg::TYP_PROC_BAND, event_cmp_pkg::TYP_DEV_BAND, event_cmp_pkg::TYP_FDEV_BAND,
      event_cmp_pkg::TYP_SETP_BAND, event_cmp_pkg::TYP_MANIP_BAND,
      event_cmp_pkg::TYP_HEAT1_BURN, event_cmp_pkg::TYP_HEAT2_BURN: return 2'b11;
      default: return 2'b00;
    endcase
  endfunction : sides_of

  // ==========================================================================
  // bus state and registers
  logic hreadyout_r;
  logic [31:0] hrdata_r;
  logic hresp_r;
  logic wr_pend_r;
  logic rd_pend_r;
  logic [7:0] wr_addr_r;
  logic [7:0] rd_addr_r;
  logic [CW-1:0] code_r;
  logic rev_r;
  logic [VW-1:0] main_r;
  logic [VW-1:0] sub_r;
  logic [VW-1:0] band_r;
  logic [IW-1:0] int_stat_r;
  logic [IW-1:0] int_mask_r;
  logic ctrl_wr_r;

  // address phase is taken only when the bus is ready
  wire logic accept = hsel & hready & htrans[event_cmp_pkg::HTRANS_ACT_BIT];
  wire logic wr_en = wr_pend_r & hready;
  wire logic wr_ctrl = wr_en & hit(wr_addr_r, event_cmp_pkg::OFS_CTRL);
  wire logic wr_main = wr_en & hit(wr_addr_r, event_cmp_pkg::OFS_MAIN);
  wire logic wr_sub = wr_en & hit(wr_addr_r, event_cmp_pkg::OFS_SUB);
  wire logic wr_band = wr_en & hit(wr_addr_r, event_cmp_pkg::OFS_BAND);
  wire logic wr_istat = wr_en & hit(wr_addr_r, event_cmp_pkg::OFS_INT_STAT);
  wire logic wr_imask = wr_en & hit(wr_addr_r, event_cmp_pkg::OFS_INT_MASK);

  // address phase capture; reads get one wait state so that a write just
  // before a read to the same register is already visible
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      rd_addr_r <= 8'h00;
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
    end else begin
      wr_pend_r <= accept & hwrite;
      rd_pend_r <= accept & ~hwrite;
      if (accept) begin
        wr_addr_r <= haddr[7:0];
        rd_addr_r <= haddr[7:0];
      end
      hreadyout_r <= ~(accept & ~hwrite);
      hresp_r <= 1'b0; // always okay
    end
  end

  // configuration registers; only whole-word transfers are expected
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      code_r <= event_cmp_pkg::CODE_RST;
      rev_r <= 1'b0;
      main_r <= event_cmp_pkg::MAIN_RST;
      sub_r <= event_cmp_pkg::SUB_RST;
      band_r <= event_cmp_pkg::BAND_RST;
      int_mask_r <= event_cmp_pkg::MASK_RST;
      ctrl_wr_r <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        code_r <= hwdata[event_cmp_pkg::CTRL_CODE_LSB +: CW];
        rev_r <= hwdata[event_cmp_pkg::CTRL_REV_BIT];
      end
      if (wr_main) main_r <= hwdata[VW-1:0];
      if (wr_sub) sub_r <= hwdata[VW-1:0];
      if (wr_band) band_r <= hwdata[VW-1:0];
      if (wr_imask) int_mask_r <= hwdata[IW-1:0];
      ctrl_wr_r <= wr_ctrl; // restarts the comparison after a code change
    end
  end

  // ==========================================================================
  // heater current readings, latched by phase of the control output
  logic [VW-1:0] cur_in [2];
  logic [VW-1:0] cur_on_r [2];
  logic [VW-1:0] cur_off_r [2];
  logic [1:0] cur_on_vld_r;
  logic [1:0] cur_off_vld_r;
  logic upd_r;

  assign cur_in[0] = current_sensor_one;
  assign cur_in[1] = current_sensor_two;

  for (genvar i = 0; i < 2; i++) begin : g_heater
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        cur_on_r[i] <= 16'h0000;
        cur_off_r[i] <= 16'h0000;
        cur_on_vld_r[i] <= 1'b0;
        cur_off_vld_r[i] <= 1'b0;
      end else if (meas_update) begin
        if (control_out_on) begin
          cur_on_r[i] <= cur_in[i];
          cur_on_vld_r[i] <= 1'b1;
        end else begin
          cur_off_r[i] <= cur_in[i];
          cur_off_vld_r[i] <= 1'b1;
        end
      end
    end
  end

  // comparison runs one cycle after the update, on the latched readings
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      upd_r <= 1'b0;
    end else begin
      upd_r <= meas_update;
    end
  end

  // ==========================================================================
  // operand selection
  wire logic [1:0] sides = sides_of(code_r);
  wire logic is_band = &sides;
  wire logic is_dev = code_r >= event_cmp_pkg::TYP_DEV_HI && code_r <= event_cmp_pkg::TYP_DEV_BAND;
  wire logic is_fdev = code_r >= event_cmp_pkg::TYP_FDEV_HI &&
                       code_r <= event_cmp_pkg::TYP_FDEV_BAND;
  wire logic is_setp = code_r >= event_cmp_pkg::TYP_SETP_HI &&
                       code_r <= event_cmp_pkg::TYP_SETP_BAND;
  wire logic is_manip = code_r >= event_cmp_pkg::TYP_MANIP_HI &&
                        code_r <= event_cmp_pkg::TYP_MANIP_BAND;
  wire logic is_heat = code_r >= event_cmp_pkg::TYP_HEAT1_BURN &&
                       code_r <= event_cmp_pkg::TYP_HEAT2_SHORT;
  wire logic heat_idx = code_r[1]; // 16,17 first sensor; 18,19 second
  wire logic heat_short = code_r[0]; // odd heater codes use the off-time reading
  wire logic [EW-1:0] main_x = event_cmp_pkg::sext(main_r);
  wire logic [EW-1:0] sub_x = event_cmp_pkg::sext(sub_r);
  wire logic swap = $signed(main_x) > $signed(sub_x);
  wire logic [EW-1:0] low_x = swap ? sub_x : main_x;
  wire logic [EW-1:0] high_x = swap ? main_x : sub_x;
  wire logic [EW-1:0] base_x = is_dev ? event_cmp_pkg::sext(target_setpoint) :
                               is_fdev ? event_cmp_pkg::sext(final_setpoint) :
                               18'h00000;
  wire logic [EW-1:0] lo_th = base_x + (is_band ? low_x : main_x);
  wire logic [EW-1:0] hi_th = base_x + (is_band ? high_x : main_x);
  wire logic [VW-1:0] heat_val = heat_short ? cur_off_r[heat_idx] : cur_on_r[heat_idx];
  wire logic [EW-1:0] sel_value = is_heat ? {2'b00, heat_val} :
                                  is_setp ? event_cmp_pkg::sext(target_setpoint) :
                                  is_manip ? event_cmp_pkg::sext(manipulated_value) :
                                  event_cmp_pkg::sext(process_value);
  wire logic heat_vld = heat_short ? cur_off_vld_r[heat_idx] : cur_on_vld_r[heat_idx];
  wire logic meas_ok = ~is_heat | heat_vld;
  // heater checks switch at the value, the others only once it is exceeded
  // in direct action; reverse action switches at the value
  wire logic edge_on_value = is_heat | rev_r;
  wire logic cmp_clear = ctrl_wr_r | ~meas_ok;
  logic cmp_state;

  hys_compare u_cmp (
    .hclk(hclk),
    .hresetn(hresetn),
    .update(upd_r),
    .clear(cmp_clear),
    .use_hi(sides[1]),
    .use_lo(sides[0]),
    .edge_on_value(edge_on_value),
    .value(sel_value),
    .lo_th(lo_th),
    .hi_th(hi_th),
    .band({2'b00, band_r}),
    .state_r(cmp_state)
  );

  // ==========================================================================
  // event decision
  wire logic status_sel = (code_r == event_cmp_pkg::TYP_ALARM) ? alarm_any :
                          (code_r == event_cmp_pkg::TYP_READY) ? ready_state :
                          (code_r == event_cmp_pkg::TYP_MANUAL) ? manual_mode :
                          (code_r == event_cmp_pkg::TYP_TUNING) ? auto_tuning :
                          (code_r == event_cmp_pkg::TYP_RAMP) ? setpoint_ramping :
                          (code_r == event_cmp_pkg::TYP_DIRECT) ? direct_action :
                          timer_state;
  wire logic is_status = code_r == event_cmp_pkg::TYP_ALARM ||
                         code_r == event_cmp_pkg::TYP_READY ||
                         code_r == event_cmp_pkg::TYP_MANUAL ||
                         code_r == event_cmp_pkg::TYP_TUNING ||
                         code_r == event_cmp_pkg::TYP_RAMP ||
                         code_r == event_cmp_pkg::TYP_DIRECT ||
                         code_r == event_cmp_pkg::TYP_TIMER;
  wire logic is_cmp = sides != 2'b00;
  // unmeasured heater readings stay off in both actions
  wire logic event_nxt = is_status ? (status_sel ^ rev_r) :
                         (is_cmp & meas_ok) ? (cmp_state ^ rev_r) :
                         1'b0;
  logic event_out_r;
  logic irq_r;

  // ==========================================================================
  // interrupt status: sticky, write one to clear, a new event wins
  wire logic [IW-1:0] int_set = {meas_update,
                                 ~event_nxt & event_out_r,
                                 event_nxt & ~event_out_r};
  wire logic [IW-1:0] int_clr = wr_istat ? hwdata[IW-1:0] : 3'h0;
  wire logic [IW-1:0] int_nxt = (int_stat_r & ~int_clr) | int_set;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      event_out_r <= 1'b0;
      int_stat_r <= 3'h0;
      irq_r <= 1'b0;
    end else begin
      event_out_r <= event_nxt;
      int_stat_r <= int_nxt;
      irq_r <= |(int_nxt & int_mask_r);
    end
  end

  // ==========================================================================
  // read data, loaded during the wait state
  wire logic [31:0] state_word = {26'h0000000, cur_off_vld_r[1], cur_on_vld_r[1],
                                  cur_off_vld_r[0], cur_on_vld_r[0], cmp_state, event_out_r};
  wire logic [31:0] rd_mux =
    hit(rd_addr_r, event_cmp_pkg::OFS_CTRL) ? {23'h000000, rev_r, 2'b00, code_r} :
    hit(rd_addr_r, event_cmp_pkg::OFS_MAIN) ? {16'h0000, main_r} :
    hit(rd_addr_r, event_cmp_pkg::OFS_SUB) ? {16'h0000, sub_r} :
    hit(rd_addr_r, event_cmp_pkg::OFS_BAND) ? {16'h0000, band_r} :
    hit(rd_addr_r, event_cmp_pkg::OFS_STATE) ? state_word :
    hit(rd_addr_r, event_cmp_pkg::OFS_INT_STAT) ? {29'h00000000, int_stat_r} :
    hit(rd_addr_r, event_cmp_pkg::OFS_INT_MASK) ? {29'h00000000, int_mask_r} :
    32'h00000000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h00000000;
    end else if (rd_pend_r) begin
      hrdata_r <= rd_mux;
    end
  end

  assign hreadyout = hreadyout_r;
  assign hrdata = hrdata_r;
  assign hresp = hresp_r;
  assign event_out = event_out_r;
  assign irq = irq_r;

  // ==========================================================================
  // checks
  sequence s_read_taken;
    accept && !hwrite;
  endsequence
  sequence s_read_wait;
    !hreadyout_r ##1 hreadyout_r;
  endsequence

  a_read_wait_state: assert property (@(posedge hclk) disable iff (!hresetn)
    s_read_taken |=> s_read_wait)
    else $error("read did not take exactly one wait state");
  a_code_zero_off: assert property (@(posedge hclk) disable iff (!hresetn)
    code_r == event_cmp_pkg::TYP_NONE |=> !event_out_r)
    else $error("event on with code zero");
  a_alarm_direct: assert property (@(posedge hclk) disable iff (!hresetn)
    code_r == event_cmp_pkg::TYP_ALARM && !rev_r |=> event_out_r == $past(alarm_any))
    else $error("alarm direct output wrong");
  a_alarm_reverse: assert property (@(posedge hclk) disable iff (!hresetn)
    code_r == event_cmp_pkg::TYP_ALARM && rev_r |=> event_out_r == !$past(alarm_any))
    else $error("alarm reverse output wrong");
  a_band_order: assert property (@(posedge hclk) disable iff (!hresetn)
    is_band |-> $signed(lo_th) <= $signed(hi_th))
    else $error("band thresholds out of order");
  a_heat_one_wait: assert property (@(posedge hclk) disable iff (!hresetn)
    code_r == event_cmp_pkg::TYP_HEAT1_BURN && !cur_on_vld_r[0] |=> !event_out_r)
    else $error("heater one on-check before reading");
  a_short_one_wait: assert property (@(posedge hclk) disable iff (!hresetn)
    code_r == event_cmp_pkg::TYP_HEAT1_SHORT && !cur_off_vld_r[0] |=> !event_out_r)
    else $error("heater one short check before reading");
  a_heat_two_wait: assert property (@(posedge hclk) disable iff (!hresetn)
    code_r == event_cmp_pkg::TYP_HEAT2_BURN && !cur_on_vld_r[1] |=> !event_out_r)
    else $error("heater two on-check before reading");
  a_short_two_wait: assert property (@(posedge hclk) disable iff (!hresetn)
    code_r == event_cmp_pkg::TYP_HEAT2_SHORT && !cur_off_vld_r[1] |=> !event_out_r)
    else $error("heater two short check before reading");
  a_final_base: assert property (@(posedge hclk) disable iff (!hresetn)
    code_r == event_cmp_pkg::TYP_FDEV_HI && upd_r && !ctrl_wr_r &&
      $signed(event_cmp_pkg::sext(process_value)) >
      $signed(EW'(event_cmp_pkg::sext(final_setpoint) + event_cmp_pkg::sext(main_r)))
      |=> cmp_state)
    else $error("final setpoint threshold wrong");
  a_ready_reflect: assert property (@(posedge hclk) disable iff (!hresetn)
    code_r == event_cmp_pkg::TYP_READY && !rev_r |=> event_out_r == $past(ready_state))
    else $error("ready status not reflected");
  a_edge_choice: assert property (@(posedge hclk) disable iff (!hresetn)
    is_heat && sides == 2'b10 && upd_r && !cmp_clear &&
      $signed(sel_value) == $signed(hi_th) |=> cmp_state)
    else $error("heater check not switching at value");

endmodule : event_output_comparator

// >>> test/event_output_comparator_tb.sv
`timescale 1ns/1ps

module event_output_comparator_tb;
  // ==========================================
  // bus, measurement and status drive
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, event_out, irq;
  logic [31:0] hrdata, rd;
  logic upd = 1'b0;
  logic ctl_on = 1'b0;
  logic [15:0] pv = 16'h0;
  logic [15:0] ct2 = 16'h0;
  logic [15:0] sp = 16'h0;
  logic [6:0] stat = 7'h0;
  logic [5:0] codes [7] = '{6'h17, 6'h18, 6'h19, 6'h1b, 6'h1c, 6'h1d, 6'h20};
  int n_errors = 0;
  int cmp_count = 0;
  always #20 hclk = ~hclk;
  // final setpoint held at 1000 so the deviation base is visible
  event_output_comparator u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .meas_update(upd), .process_value(pv), .target_setpoint(sp),
    .final_setpoint(16'h03e8), .manipulated_value(16'h0000), .current_sensor_one(pv),
    .current_sensor_two(ct2), .control_out_on(ctl_on), .alarm_any(stat[0]),
    .ready_state(stat[1]), .manual_mode(stat[2]), .auto_tuning(stat[3]),
    .setpoint_ramping(stat[4]), .direct_action(stat[5]), .timer_state(stat[6]),
    .event_out(event_out), .irq(irq));

  // ==========================================
  // tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_sim();
    $display("compares %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim
  // bounded wait for hready; a hang counts as a mismatch
  task automatic wait_rdy();
    int i;
    i = 0;
    do begin
      @(posedge hclk);
      i++;
    end while (hreadyout !== 1'b1 && i < 50);
    if (hreadyout !== 1'b1) begin
      n_errors++;
      end_sim();
    end
  endtask : wait_rdy
  // one single transfer; read data lands in rd
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    // hsel stays high: an idle htrans keeps the bus quiet between calls
    rd = hrdata;
  endtask : bus
  // one update pulse; event_out settles two edges after it is taken
  task automatic meas(input logic [15:0] v, input logic on, input logic exp);
    pv <= v;
    ctl_on <= on;
    upd <= 1'b1;
    @(posedge hclk);
    upd <= 1'b0;
    repeat (3) @(posedge hclk);
    check(event_out, exp);
  endtask : meas

  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, 8'h00, 0);
    check(rd, 0);
    bus(1'b0, 8'h40, 0);
    check(rd, 0);
    bus(1'b1, 8'h04, 100);
    bus(1'b1, 8'h0c, 10);
    bus(1'b1, 8'h18, 1);
    bus(1'b1, 8'h00, 32'h100);
    meas(16'd500, 1'b0, 1'b0);
    bus(1'b1, 8'h00, 1);
    bus(1'b1, 8'h14, 7);
    meas(16'd100, 1'b0, 1'b0);
    meas(16'd101, 1'b0, 1'b1);
    check(irq, 1'b1);
    bus(1'b1, 8'h14, 1);
    bus(1'b0, 8'h14, 0);
    check(rd, 32'h4);
    check(irq, 1'b0);
    meas(16'd95, 1'b0, 1'b1);
    meas(16'd89, 1'b0, 1'b0);
    bus(1'b1, 8'h00, 7);
    meas(16'd1100, 1'b0, 1'b0);
    meas(16'd1101, 1'b0, 1'b1);
    // misordered band limits, heater one readings
    bus(1'b1, 8'h04, 200);
    bus(1'b1, 8'h08, 50);
    bus(1'b1, 8'h00, 16);
    meas(16'd250, 1'b0, 1'b0);
    meas(16'd250, 1'b1, 1'b1);
    meas(16'd120, 1'b1, 1'b0);
    bus(1'b1, 8'h00, 17);
    meas(16'd200, 1'b0, 1'b1);
    // status codes, both levels, both actions
    for (int s = 0; s < 2; s++) begin
      stat <= s[0] ? 7'h7f : 7'h00;
      foreach (codes[k]) begin
        bus(1'b1, 8'h00, {26'h0, codes[k]});
        repeat (3) @(posedge hclk);
        check(event_out, s[0]);
        bus(1'b1, 8'h00, {26'h4, codes[k]});
        repeat (3) @(posedge hclk);
        check(event_out, !s[0]);
      end
    end
    // second reset: heater readings must be invalid again
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check(event_out, 1'b0);
    check(irq, 1'b0);
    ct2 <= 16'd250;
    bus(1'b1, 8'h04, 200);
    bus(1'b1, 8'h08, 50);
    bus(1'b1, 8'h00, 18);
    meas(16'd250, 1'b0, 1'b0);
    bus(1'b0, 8'h10, 0);
    check(rd, 32'h28);
    meas(16'd120, 1'b1, 1'b1);
    ct2 <= 16'd120;
    meas(16'd250, 1'b1, 1'b0);
    ct2 <= 16'd210;
    bus(1'b1, 8'h00, 19);
    meas(16'd10, 1'b0, 1'b1);
    check(hresp, 1'b0);
    // setpoint based deviation and absolute setpoint and output codes
    sp <= 16'd300;
    bus(1'b1, 8'h00, 4);
    meas(16'd500, 1'b0, 1'b0);
    meas(16'd501, 1'b0, 1'b1);
    bus(1'b1, 8'h00, 10);
    meas(16'd0, 1'b0, 1'b1);
    bus(1'b1, 8'h00, 14);
    meas(16'd0, 1'b0, 1'b1);
    end_sim();
  end
endmodule : event_output_comparator_tb
